/* design/spi_eeprom_write_guard.v */
// Serial EEPROM slave: command decoder, array, counter words and write guard.
// Assumes serial pins are asynchronous to clk_i and are synchronised here.
`timescale 1ns/1ps
`include "guard_regs.vh"
module spi_eeprom_write_guard (
	input  wire       clk_i,      // 200 MHz system clock
	input  wire       resetn_i,   // Asynchronous reset, active low
	input  wire       sclk_i,     // Serial clock pin
	input  wire       sdi_i,      // Serial data in pin
	input  wire       select_n_i, // Select pin, active low
	input  wire       guard_pin_n_i, // Guard pin, low protects; pulled low
	output reg        sdo_o,      // Serial data out
	output wire       sdo_oe_o,   // Output enable for sdo_o
	output wire       standby_o,  // Low power standby indication
	output wire       hard_lock_o // Hard lock mode active
);
	localparam WRITE_CYCLES = (`WRITE_TIME_NS + `CLK_NS - 1) / `CLK_NS;
	localparam S_OP   = 6'b000001;
	localparam S_ADHI = 6'b000010;
	localparam S_ADLO = 6'b000100;
	localparam S_DATA = 6'b001000;
	localparam S_IDLE = 6'b010000;
	localparam S_RD   = 6'b100000;

	reg [2:0]  sclk_sync_reg;
	reg [1:0]  sdi_sync_reg;
	reg [2:0]  sel_sync_reg;
	reg [1:0]  guard_sync_reg;
	wire       sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	wire       sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
	wire       sel_n     = sel_sync_reg[1];
	wire       sel_fall  = ~sel_sync_reg[1] & sel_sync_reg[2];
	wire       sel_rise  = sel_sync_reg[1] & ~sel_sync_reg[2];
	wire       guard_hi  = guard_sync_reg[1];
	wire       sdi       = sdi_sync_reg[1];

	reg [7:0]  mem [0:`MEM_DEPTH-1];
	reg [7:0]  page_buf [0:31];
	reg        woken_reg;
	reg [5:0]  state_reg;
	reg [2:0]  bit_cnt_reg;
	reg [7:0]  shift_reg;
	reg [7:0]  opcode_reg;
	reg [9:0]  addr_reg;
	reg [9:0]  wr_base_reg;
	reg [5:0]  wr_count_reg;
	reg [7:0]  tx_reg;
	reg        tx_valid_reg;
	reg        lock_reg;
	reg        erased_reg;
	reg        compare_reg;
	reg [1:0]  guard_bits_reg;
	reg        arm_reg;
	reg        busy_reg;
	reg [7:0]  status_new_reg;
	reg        st_pending_reg;
	reg [15:0] busy_cnt_reg;
	reg        is_counter_reg;
	reg [5:0]  commit_idx_reg;
	reg        st_commit_reg;
	integer    i;

	wire [7:0] status_rd = {lock_reg, erased_reg, compare_reg, 1'b0,
		guard_bits_reg[1], guard_bits_reg[0], arm_reg, busy_reg};
	wire       hard_lock = lock_reg & ~guard_hi;
	wire [7:0] next_byte = {shift_reg[6:0], sdi};
	assign hard_lock_o = hard_lock;
	assign sdo_oe_o    = ~sel_n & woken_reg;
	assign standby_o   = sel_n & ~busy_reg;

	// Guarded region decode, applied in both soft and hard guard modes
	function guarded;
		input [9:0] a;
		input [1:0] g;
		begin
			case (g)
				2'b01:   guarded = (a >= `GUARD_QUARTER);
				2'b10:   guarded = (a >= `GUARD_HALF);
				2'b11:   guarded = 1'b1;
				default: guarded = 1'b0;
			endcase
		end
	endfunction

	function is_known_op;
		input [7:0] op;
		begin
			is_known_op = (op == `OP_ARM) | (op == `OP_DISARM) | (op == `OP_RD_STATUS) |
				(op == `OP_WR_STATUS) | (op == `OP_RD_ARRAY) | (op == `OP_WR_ARRAY) |
				(op == `OP_WR_COUNTER);
		end
	endfunction

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclk_sync_reg  <= 3'b000;
			sdi_sync_reg   <= 2'b00;
			sel_sync_reg   <= 3'b111;
			guard_sync_reg <= 2'b00;
		end else begin
			sclk_sync_reg  <= {sclk_sync_reg[1:0], sclk_i};
			sdi_sync_reg   <= {sdi_sync_reg[0], sdi_i};
			sel_sync_reg   <= {sel_sync_reg[1:0], select_n_i};
			guard_sync_reg <= {guard_sync_reg[0], guard_pin_n_i};
		end
	end

	// Counter word stored at page_buf index pair; compare whole 16-bit word
	wire [9:0]  c_addr  = {wr_base_reg[9:1], 1'b0};
	wire [15:0] c_old   = {mem[c_addr], mem[c_addr + 10'd1]};
	wire [15:0] c_new   = {page_buf[{commit_idx_reg[4:1], 1'b0}],
		page_buf[{commit_idx_reg[4:1], 1'b1}]};
	wire [9:0]  w_addr  = {wr_base_reg[9:5], wr_base_reg[4:0] + commit_idx_reg[4:0]};

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			woken_reg      <= 1'b0;
			state_reg      <= S_IDLE;
			bit_cnt_reg    <= 3'd0;
			shift_reg      <= 8'h00;
			opcode_reg     <= 8'h00;
			addr_reg       <= 10'h000;
			wr_base_reg    <= 10'h000;
			wr_count_reg   <= 6'd0;
			tx_reg         <= 8'h00;
			tx_valid_reg   <= 1'b0;
			sdo_o          <= 1'b0;
			lock_reg       <= 1'b0;
			erased_reg     <= 1'b1;
			compare_reg    <= 1'b0;
			guard_bits_reg <= 2'b00;
			arm_reg        <= 1'b0;
			busy_reg       <= 1'b0;
			status_new_reg <= 8'h00;
			st_pending_reg <= 1'b0;
			busy_cnt_reg   <= 16'd0;
			is_counter_reg <= 1'b0;
			commit_idx_reg <= 6'd0;
			st_commit_reg  <= 1'b0;
		end else begin
			if (sel_fall) begin
				woken_reg   <= 1'b1;
				state_reg   <= S_OP;
				bit_cnt_reg <= 3'd0;
				tx_valid_reg <= 1'b0;
			end else if (sel_rise) begin
				state_reg <= S_IDLE;
				// Write starts only after whole bytes were received
				if (woken_reg && bit_cnt_reg == 3'd0 && !busy_reg) begin
					if (opcode_reg == `OP_WR_STATUS && status_new_reg != 8'h00 ||
						opcode_reg == `OP_WR_STATUS && st_pending_reg) begin
						if (arm_reg && !hard_lock) begin
							lock_reg       <= status_new_reg[`ST_LOCK];
							guard_bits_reg <= status_new_reg[`ST_GUARD_HI:`ST_GUARD_LO];
							st_commit_reg  <= 1'b1;
							busy_reg       <= 1'b1;
							busy_cnt_reg   <= WRITE_CYCLES[15:0];
						end
						arm_reg <= 1'b0;
					end else if ((opcode_reg == `OP_WR_ARRAY || opcode_reg == `OP_WR_COUNTER)
						&& wr_count_reg != 6'd0) begin
						if (arm_reg || is_counter_reg) begin
							busy_reg       <= 1'b1;
							busy_cnt_reg   <= WRITE_CYCLES[15:0];
							commit_idx_reg <= 6'd0;
							st_commit_reg  <= 1'b0;
						end
						arm_reg <= 1'b0;
					end
				end
			end else if (!sel_n && woken_reg && sclk_rise && state_reg != S_IDLE) begin
				shift_reg   <= next_byte;
				bit_cnt_reg <= bit_cnt_reg + 3'd1;
				if (bit_cnt_reg == 3'd7) begin
					case (state_reg)
						S_OP: begin
							opcode_reg     <= next_byte;
							st_pending_reg <= 1'b0;
							// A status poll during a write cycle must not lose the page
							if (!busy_reg) begin
								wr_count_reg <= 6'd0;
							end
							if (!is_known_op(next_byte)) begin
								state_reg <= S_IDLE;
							end else if (next_byte == `OP_ARM) begin
								arm_reg   <= 1'b1;
								state_reg <= S_IDLE;
							end else if (next_byte == `OP_DISARM) begin
								arm_reg   <= 1'b0;
								state_reg <= S_IDLE;
							end else if (next_byte == `OP_RD_STATUS) begin
								tx_reg       <= status_rd;
								tx_valid_reg <= 1'b1;
								state_reg    <= S_RD;
							end else if (next_byte == `OP_WR_STATUS) begin
								state_reg <= S_DATA;
							end else begin
								state_reg <= S_ADHI;
							end
						end
						S_ADHI: begin
							addr_reg[9:8] <= next_byte[1:0];
							state_reg     <= S_ADLO;
						end
						S_ADLO: begin
							addr_reg[7:0] <= next_byte;
							if (!busy_reg) begin
								wr_base_reg    <= {addr_reg[9:8], next_byte};
								is_counter_reg <= ({addr_reg[9:8], next_byte} <= `COUNTER_TOP);
							end
							if (opcode_reg == `OP_RD_ARRAY) begin
								tx_reg       <= mem[{addr_reg[9:8], next_byte}];
								tx_valid_reg <= 1'b1;
								addr_reg     <= {addr_reg[9:8], next_byte} + 10'd1;
								state_reg    <= S_RD;
							end else begin
								state_reg <= S_DATA;
							end
						end
						S_DATA: begin
							if (opcode_reg == `OP_WR_STATUS) begin
								status_new_reg <= next_byte;
								st_pending_reg <= 1'b1;
								state_reg      <= S_IDLE;
							end else if (wr_count_reg < `PAGE_BYTES && !busy_reg) begin
								page_buf[wr_count_reg[4:0]] <= next_byte;
								wr_count_reg <= wr_count_reg + 6'd1;
							end
						end
						default: state_reg <= S_IDLE;
					endcase
				end
			end else if (!sel_n && woken_reg && sclk_fall && state_reg == S_RD) begin
				sdo_o <= tx_reg[7];
				tx_valid_reg <= 1'b0;
				tx_reg       <= {tx_reg[6:0], 1'b0};
				if (bit_cnt_reg == 3'd7) begin
					if (opcode_reg == `OP_RD_STATUS) begin
						tx_reg <= status_rd;
					end else begin
						tx_reg   <= mem[addr_reg];
						addr_reg <= addr_reg + 10'd1;
					end
				end
			end

			// Self-timed write cycle, finishes even when deselected
			if (busy_reg) begin
				if (busy_cnt_reg != 16'd0) begin
					busy_cnt_reg <= busy_cnt_reg - 16'd1;
				end else if (st_commit_reg) begin
					busy_reg <= 1'b0;
				end else if (commit_idx_reg < wr_count_reg) begin
					if (is_counter_reg) begin
						// Counter area takes one aligned word, no page roll
						if (c_new > c_old && wr_count_reg >= 6'd2) begin
							mem[c_addr]         <= c_new[15:8];
							mem[c_addr + 10'd1] <= c_new[7:0];
							compare_reg         <= 1'b0;
						end else begin
							compare_reg <= 1'b1;
						end
						commit_idx_reg <= wr_count_reg;
					end else begin
						if (!guarded(w_addr, guard_bits_reg)) begin
							mem[w_addr] <= page_buf[commit_idx_reg[4:0]];
							erased_reg  <= 1'b0;
						end
						commit_idx_reg <= commit_idx_reg + 6'd1;
					end
				end else begin
					busy_reg <= 1'b0;
				end
			end
		end
	end

	initial begin
		for (i = 0; i < `MEM_DEPTH; i = i + 1) begin
			mem[i] = 8'h00;
		end
	end
endmodule // spi_eeprom_write_guard

/* design/guard_regs.vh */
// Constants for the serial EEPROM front end with write guard.
// Assumes a single system clock that oversamples the serial clock pin.
`ifndef GUARD_REGS_VH
`define GUARD_REGS_VH
`define OP_ARM        8'h06
`define OP_DISARM     8'h04
`define OP_RD_STATUS  8'h05
`define OP_WR_STATUS  8'h01
`define OP_RD_ARRAY   8'h03
`define OP_WR_ARRAY   8'h02
`define OP_WR_COUNTER 8'h07
`define ST_LOCK       7
`define ST_ERASED     6
`define ST_COMPARE    5
`define ST_GUARD_HI   3
`define ST_GUARD_LO   2
`define ST_ARM        1
`define ST_BUSY       0
`define MEM_DEPTH     1024
`define PAGE_BYTES    6'd32
`define PAGE_MASK     10'h3e0
`define COUNTER_TOP   10'h01f
`define GUARD_QUARTER 10'h300
`define GUARD_HALF    10'h200
`define WRITE_TIME_NS 5000
`define CLK_NS        5
`endif

/* dv/guard_checker_sva.sv */
// Port checker for the serial EEPROM write guard block.
// Assumes pin synchronisers settle within three clk_i cycles.
`timescale 1ns/1ps
module guard_checker_sva (
	input logic clk_i,         // System clock
	input logic resetn_i,      // Reset, active low
	input logic sclk_i,        // Serial clock pin
	input logic select_n_i,    // Select, active low
	input logic guard_pin_n_i, // Guard pin
	input logic sdo_o,         // Serial data out
	input logic sdo_oe_o,      // Output enable
	input logic standby_o,     // Standby flag
	input logic hard_lock_o    // Hard lock flag
);
	logic [10:0] idle_cnt;
	// Counts deselected cycles; saturates so a long idle never wraps
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			idle_cnt <= 11'h000;
		else if (!select_n_i)
			idle_cnt <= 11'h000;
		else if (idle_cnt != 11'h7ff)
			idle_cnt <= idle_cnt + 11'h001;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_guard_low;
		!guard_pin_n_i[*3];
	endsequence
	a_hiz_desel: assert property (select_n_i[*3] |-> !sdo_oe_o)
		else $error("output enabled while deselected");
	a_oe_on_sel: assert property ($fell(select_n_i) |-> ##4 sdo_oe_o)
		else $error("output not enabled after select");
	a_sdo_on_fall: assert property ($rose(sclk_i) |=> $stable(sdo_o)[*3])
		else $error("output moved after clock rise");
	a_sdo_quiet: assert property (select_n_i[*5] |-> $stable(sdo_o))
		else $error("output moved while deselected");
	a_standby_sel: assert property ($fell(select_n_i) |-> ##3 !standby_o)
		else $error("standby while selected");
	a_standby_idle: assert property (idle_cnt == 11'h4b0 |-> standby_o)
		else $error("no standby after long idle");
	a_guard_free: assert property (guard_pin_n_i[*4] |-> !hard_lock_o)
		else $error("hard lock with guard pin high");
	a_lock_rise: assert property ($rose(hard_lock_o)
		|-> !$past(guard_pin_n_i, 2) || !$past(guard_pin_n_i, 3))
		else $error("hard lock rose with guard pin high");
	a_lock_holds: assert property (s_guard_low ##0 hard_lock_o |=> hard_lock_o)
		else $error("hard lock left while guard pin low");
endmodule // guard_checker_sva
bind spi_eeprom_write_guard guard_checker_sva i_chk (.clk_i, .resetn_i, .sclk_i, .select_n_i,
	.guard_pin_n_i, .sdo_o, .sdo_oe_o, .standby_o, .hard_lock_o);

/* dv/spi_host_model.sv */
// Host bus master model for the serial pins of the guard block.
// Assumes mode 0 framing; the serial clock stands low between frames.
`timescale 1ns/1ps
module spi_host_model (
	input  logic sdo_i,      // Device serial output
	output logic sclk_o,     // Serial clock
	output logic sdi_o,      // Serial data to device
	output logic select_n_o  // Select, active low
);
	int half_ns = 32;
	initial begin
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		select_n_o = 1'b1;
	end
	// Released data line shows the inverse so a stale bit is never reused
	task automatic frame(input logic [39:0] tx, input int n, output logic [7:0] rx);
		select_n_o = 1'b0;
		for (int i = 0; i < n * 8; i++) begin
			sdi_o = tx[39 - i];
			#(half_ns) sclk_o = 1'b1;
			rx = {rx[6:0], sdo_i};
			#(half_ns) sclk_o = 1'b0;
		end
		#(half_ns) select_n_o = 1'b1;
		sdi_o = ~sdi_o;
		#(2 * half_ns);
	endtask
endmodule // spi_host_model

/* dv/tb_top.sv */
// Self-checking bench for the serial EEPROM write guard block.
// Assumes the host model drives the serial pins with its own timing.
`timescale 1ns/1ps
`include "guard_regs.vh"
module tb_top;
	logic       clk_i, resetn_i, sclk_i, sdi_i, select_n_i, guard_pin_n_i;
	logic       sdo_o, sdo_oe_o, standby_o, hard_lock_o;
	logic [7:0] rx;
	int         err_count = 0;
	int         comparisons = 0;
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	spi_eeprom_write_guard i_dut (.clk_i, .resetn_i, .sclk_i, .sdi_i, .select_n_i,
		.guard_pin_n_i, .sdo_o, .sdo_oe_o, .standby_o, .hard_lock_o);
	spi_host_model i_host (.sdo_i(sdo_o), .sclk_o(sclk_i), .sdi_o(sdi_i), .select_n_o(select_n_i));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] op, input logic [31:0] rest, input int n);
		i_host.frame({op, rest}, n, rx);
	endtask
	task automatic idle;
		rx = 8'h01;
		for (int k = 0; k < 40 && rx[0] !== 1'b0; k++)
			cmd(`OP_RD_STATUS, 32'h0, 2);
		chk(rx & 8'h01, 8'h00);
	endtask
	task automatic wr(input logic [7:0] op, input logic [9:0] a, input logic [15:0] d,
		input int n, input bit arm);
		if (arm)
			cmd(`OP_ARM, 32'h0, 1);
		cmd(op, {6'h00, a, d}, n);
		idle();
	endtask
	task automatic ws(input logic [7:0] v);
		cmd(`OP_ARM, 32'h0, 1);
		cmd(`OP_WR_STATUS, {v, 24'h0}, 2);
		idle();
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		cmd(`OP_RD_ARRAY, {6'h00, a, 16'h0}, 4);
		chk(rx, exp);
	endtask
	task automatic stat(input logic [7:0] mask, input logic [7:0] exp);
		cmd(`OP_RD_STATUS, 32'h0, 2);
		chk(rx & mask, exp);
	endtask
	task automatic t_arm;
		stat(8'hff, 8'h40);
		cmd(`OP_ARM, 32'h0, 1);
		stat(8'hff, 8'h42);
		cmd(`OP_DISARM, 32'h0, 1);
		stat(8'hff, 8'h40);
		cmd(8'hff, {`OP_ARM, 24'h0}, 2);
		stat(8'hff, 8'h40);
	endtask
	task automatic t_array;
		wr(`OP_WR_ARRAY, 10'h045, 16'ha55a, 5, 1);
		rd(10'h045, 8'ha5);
		rd(10'h046, 8'h5a);
		stat(8'h02, 8'h00);
		wr(`OP_WR_ARRAY, 10'h045, 16'h1200, 4, 0);
		rd(10'h045, 8'ha5);
	endtask
	task automatic t_counter;
		wr(`OP_WR_COUNTER, 10'h004, 16'h0102, 5, 0);
		rd(10'h004, 8'h01);
		rd(10'h005, 8'h02);
		wr(`OP_WR_COUNTER, 10'h004, 16'h0101, 5, 0);
		rd(10'h005, 8'h02);
		stat(8'h20, 8'h20);
	endtask
	task automatic t_guard;
		wr(`OP_WR_STATUS, 10'h000, 16'h0000, 1, 1);
		ws(8'h8c);
		stat(8'h8c, 8'h8c);
		@(posedge clk_i);
		guard_pin_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk({7'h00, hard_lock_o}, 8'h01);
		wr(`OP_WR_STATUS, 10'h000, 16'h0, 2, 1);
		stat(8'h8c, 8'h8c);
		wr(`OP_WR_ARRAY, 10'h100, 16'h7700, 4, 1);
		rd(10'h100, 8'h00);
		guard_pin_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk({7'h00, hard_lock_o}, 8'h00);
		ws(8'h04);
		stat(8'h8c, 8'h04);
		wr(`OP_WR_ARRAY, 10'h300, 16'h7700, 4, 1);
		rd(10'h300, 8'h00);
		repeat (1300) @(posedge clk_i);
		chk({7'h00, standby_o}, 8'h01);
	endtask
	task automatic final_report;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		resetn_i = 1'b0;
		guard_pin_n_i = 1'b1;
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_arm();
		t_array();
		t_counter();
		t_guard();
		final_report();
	end
	initial begin
		#450_000;
		err_count++;
		final_report();
	end
endmodule // tb_top
